// ===== pss_pkg.sv
/*
 * Shared constants and types for the power-on self-test sequencer:
 * strap value, lamp patterns, tick and phase timing, driver bundle, states.
 * Assumes a single 125 MHz clock and an active-low asynchronous reset.
 */
package pss_pkg;
    // System clock rate and the internal logic tick rate, in Hz
    localparam int unsigned CLOCK_HZ = 125000000;
    localparam int unsigned TICK_HZ = 960000;
    localparam logic [26:0] TICK_MOD = 27'h7735940; // CLOCK_HZ as accumulator width
    localparam logic [26:0] TICK_STEP = 27'h00EA600; // TICK_HZ as accumulator width

    // Medium-selection switch position that selects self-test
    localparam logic [3:0] SELF_TEST_POS = 4'hF;

    // Phase lengths as printed, in ms, and in ticks
    localparam int unsigned PHASE_LAMP_TC_MS = 600;
    localparam int unsigned PHASE_LAMP_REST_MS = 400;
    localparam int unsigned PHASE_LAMP_TC_TICKS = PHASE_LAMP_TC_MS * (TICK_HZ / 1000);
    localparam int unsigned PHASE_LAMP_REST_TICKS = PHASE_LAMP_REST_MS * (TICK_HZ / 1000);

    // Narrow driver pulse, in ns, rounded up to whole ticks
    localparam int unsigned PULSE_NS = 10000;
    localparam int unsigned PULSE_TICKS_I = (PULSE_NS * (TICK_HZ / 1000) + 999999) / 1000000;
    localparam logic [3:0] PULSE_TICKS = PULSE_TICKS_I[3:0];

    // Lamp patterns, bit 7 is the leftmost test-complete lamp
    localparam logic [7:0] LAMPS_OFF = 8'h00;
    localparam logic [7:0] LAMPS_TC_ONLY = 8'h80;
    localparam logic [7:0] LAMPS_REST_ONLY = 8'h7F;
    localparam logic [7:0] LAMPS_FAILED = 8'hFF;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LAMP_TC = 2'b01,
        ST_LAMP_REST = 2'b10,
        ST_FAIL = 2'b11
    } pss_state_t;

    // Line driver levels, 1 is the high (positive) line level
    typedef struct packed {
        logic v24TxData;     // Serial pin 2, positive pulse
        logic v24ReqSend;    // Serial pin 4, positive pulse
        logic v24TermReady;  // Serial pin 20, positive pulse, held low by switch
        logic v25Line2;      // Dialler pin 2, positive pulse
        logic v25Line4;      // Dialler pin 4, positive pulse
        logic v25Line14;     // Dialler pin 14, positive pulse
        logic v25Line15;     // Dialler pin 15, negative pulse
        logic v25Line16;     // Dialler pin 16, positive pulse
        logic v25Line17;     // Dialler pin 17, negative pulse
    } pss_drivers_t;

    localparam pss_drivers_t DRIVERS_IDLE = 9'h005;
    localparam pss_drivers_t DRIVERS_PULSE = 9'h1FA;
endpackage : pss_pkg

// ===== pss_phase_timer.sv
/*
 * Phase timer: counts logic ticks from a restart up to a limit and gives
 * a one-cycle expiry pulse. Assumes tick is a one-cycle strobe.
 */
`timescale 1ns/10ps
module pss_phase_timer (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic restart,
    input wire logic tick,
    input wire logic [19:0] limit,
    output logic expired
);
    import pss_pkg::*;

    logic [19:0] count_r; // Ticks since restart

    // Count ticks; wrap and flag at the limit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= 20'h00000;
            expired <= 1'b0;
        end else if (restart) begin
            count_r <= 20'h00000;
            expired <= 1'b0;
        end else if (tick && (count_r == limit - 20'h00001)) begin
            count_r <= 20'h00000;
            expired <= 1'b1;
        end else if (tick) begin
            count_r <= count_r + 20'h00001;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Count never passes the limit
    property p_count_bound;
        (count_r < limit) || restart;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("phase count beyond limit");
endmodule : pss_phase_timer

// ===== pss_self_test.sv
/*
 * Power-on self-test sequencer: catches the medium switch once after reset,
 * runs the two-phase lamp cycle and pulses the line drivers each cycle.
 * Assumes synchronous switch inputs and a 125 MHz clock.
 */
`timescale 1ns/10ps
module pss_self_test #(
    parameter logic [19:0] PHASE_TC_TICKS = pss_pkg::PHASE_LAMP_TC_TICKS[19:0],
    parameter logic [19:0] PHASE_REST_TICKS = pss_pkg::PHASE_LAMP_REST_TICKS[19:0]
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] mediumSwitch,
    input wire logic dtrSwitch,
    input wire logic checkFault,
    output logic [7:0] lamps_r,
    output logic selfTestActive_r,
    output pss_pkg::pss_drivers_t drivers_r
);
    import pss_pkg::*;

    pss_state_t state_r;      // Sequencer state
    pss_state_t stateQ_r;     // State that the lamps currently show
    logic captured_r;         // Switch already sampled since reset
    logic [26:0] tickAcc_r;   // Fractional tick accumulator
    logic tick_r;             // One-cycle logic tick strobe
    logic [3:0] pulseCnt_r;   // Ticks left in the driver pulse
    logic expired;            // Phase timer expiry
    logic phaseStart;         // A phase begins on this edge
    logic cycleStart;         // The lamp cycle restarts on this edge
    logic fault;              // Any internal check failed
    logic [19:0] phaseLimit;  // Length of the running phase
    logic [27:0] accSum;      // Accumulator plus step

    // Lamp pattern shown for each state
    function automatic logic [7:0] lampPattern(input pss_state_t st);
        logic [7:0] pat;
        pat = LAMPS_OFF;
        case (st)
            ST_LAMP_TC: pat = LAMPS_TC_ONLY;
            ST_LAMP_REST: pat = LAMPS_REST_ONLY;
            ST_FAIL: pat = LAMPS_FAILED;
            default: pat = LAMPS_OFF;
        endcase
        return pat;
    endfunction : lampPattern

    // Fractional divider: exact 960 kHz on average, no drift from rounding
    assign accSum = {1'b0, tickAcc_r} + {1'b0, TICK_STEP};
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tickAcc_r <= 27'h0000000;
            tick_r <= 1'b0;
        end else if (accSum >= {1'b0, TICK_MOD}) begin
            tickAcc_r <= 27'(accSum - {1'b0, TICK_MOD});
            tick_r <= 1'b1;
        end else begin
            tickAcc_r <= accSum[26:0];
            tick_r <= 1'b0;
        end
    end

    // Strap is caught on the first edge after release, never later
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            captured_r <= 1'b0;
        end else begin
            captured_r <= 1'b1;
        end
    end

    // Fault covers outside checks and a lamp readback mismatch;
    // switches and line drivers cannot be judged here at all
    assign fault = checkFault || (lamps_r != lampPattern(stateQ_r));
    assign cycleStart = (state_r == ST_IDLE && !captured_r && mediumSwitch == SELF_TEST_POS)
        || (state_r == ST_LAMP_REST && expired && !fault);
    // Failure holds the timer cleared, so a long phase count never outlives its limit
    assign phaseStart = cycleStart || (state_r == ST_LAMP_TC && expired && !fault)
        || (state_r == ST_FAIL);
    assign phaseLimit = (state_r == ST_LAMP_TC) ? PHASE_TC_TICKS : PHASE_REST_TICKS;

    // Phase length timer
    pss_phase_timer u_phase_timer (
        .clock(clock),
        .reset_n(reset_n),
        .restart(phaseStart),
        .tick(tick_r),
        .limit(phaseLimit),
        .expired(expired)
    );

    // Sequencer state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // Only the power-up sample may start the test
                    if (!captured_r && mediumSwitch == SELF_TEST_POS) begin
                        state_r <= ST_LAMP_TC;
                    end
                end
                ST_LAMP_TC: begin
                    if (fault) begin
                        state_r <= ST_FAIL;
                    end else if (expired) begin
                        state_r <= ST_LAMP_REST;
                    end
                end
                ST_LAMP_REST: begin
                    if (fault) begin
                        state_r <= ST_FAIL;
                    end else if (expired) begin
                        state_r <= ST_LAMP_TC;
                    end
                end
                default: begin
                    // Failure is left only through reset
                    state_r <= ST_FAIL;
                end
            endcase
        end
    end

    // Lamps follow the state one edge later
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lamps_r <= LAMPS_OFF;
            stateQ_r <= ST_IDLE;
        end else begin
            lamps_r <= lampPattern(state_r);
            stateQ_r <= state_r;
        end
    end

    // Active flag for the rest of the instrument
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            selfTestActive_r <= 1'b0;
        end else begin
            selfTestActive_r <= (state_r != ST_IDLE);
        end
    end

    // Narrow pulse armed once per lamp cycle, timed in ticks
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pulseCnt_r <= 4'h0;
        end else if (state_r == ST_FAIL) begin
            pulseCnt_r <= 4'h0;
        end else if (cycleStart) begin
            pulseCnt_r <= PULSE_TICKS;
        end else if (tick_r && pulseCnt_r != 4'h0) begin
            pulseCnt_r <= pulseCnt_r - 4'h1;
        end
    end

    // Driver levels; each line idles opposite to its pulse
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            drivers_r <= DRIVERS_IDLE;
        end else begin
            drivers_r <= (pulseCnt_r != 4'h0) ? DRIVERS_PULSE : DRIVERS_IDLE;
            if (dtrSwitch) begin
                // Held switch wins over the pulse
                drivers_r.v24TermReady <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Reset must already be released at the sampling edge itself
    sequence s_strap_hit;
        reset_n && !captured_r && mediumSwitch == SELF_TEST_POS;
    endsequence

    sequence s_enter_tc;
        state_r != ST_LAMP_TC ##1 state_r == ST_LAMP_TC;
    endsequence

    property p_strap_start;
        s_strap_hit |=> state_r == ST_LAMP_TC ##1 lamps_r == LAMPS_TC_ONLY;
    endproperty
    a_strap_start: assert property (p_strap_start) else $error("strap did not start test");

    property p_no_late_start;
        captured_r && state_r == ST_IDLE |=> state_r == ST_IDLE;
    endproperty
    a_no_late_start: assert property (p_no_late_start) else $error("late switch started test");

    property p_two_states;
        state_r == ST_LAMP_TC || state_r == ST_LAMP_REST
            |=> lamps_r == LAMPS_TC_ONLY || lamps_r == LAMPS_REST_ONLY;
    endproperty
    a_two_states: assert property (p_two_states) else $error("lamp pattern not one of two");

    property p_tc_phase;
        s_enter_tc |=> lamps_r == LAMPS_TC_ONLY;
    endproperty
    a_tc_phase: assert property (p_tc_phase) else $error("test lamp phase wrong");

    property p_rest_phase;
        state_r == ST_LAMP_TC ##1 state_r == ST_LAMP_REST |=> lamps_r == LAMPS_REST_ONLY;
    endproperty
    a_rest_phase: assert property (p_rest_phase) else $error("other lamps phase wrong");

    property p_order;
        $changed(state_r) && state_r == ST_LAMP_REST |-> $past(state_r) == ST_LAMP_TC;
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");

    property p_fail_sticks;
        state_r == ST_FAIL |=> state_r == ST_FAIL ##1 lamps_r == LAMPS_FAILED;
    endproperty
    a_fail_sticks: assert property (p_fail_sticks) else $error("failure not held");

    property p_fault_stops;
        (state_r == ST_LAMP_TC || state_r == ST_LAMP_REST) && checkFault |=> state_r == ST_FAIL;
    endproperty
    a_fault_stops: assert property (p_fault_stops) else $error("fault did not stop lamps");

    property p_dtr_held;
        dtrSwitch |=> !drivers_r.v24TermReady;
    endproperty
    a_dtr_held: assert property (p_dtr_held) else $error("DTR not held low");

    property p_pulse_arm;
        s_enter_tc |-> pulseCnt_r == PULSE_TICKS;
    endproperty
    a_pulse_arm: assert property (p_pulse_arm) else $error("pulse not armed");

    property p_idle_levels;
        pulseCnt_r == 4'h0 && !dtrSwitch |=> drivers_r == DRIVERS_IDLE;
    endproperty
    a_idle_levels: assert property (p_idle_levels) else $error("driver idle level wrong");

    property p_pulse_levels;
        pulseCnt_r != 4'h0 |=> drivers_r.v25Line2 && !drivers_r.v25Line15;
    endproperty
    a_pulse_levels: assert property (p_pulse_levels) else $error("driver pulse level wrong");

    property p_tick_spacing;
        tick_r |=> !tick_r [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too fast");
endmodule : pss_self_test

// ===== pss_operator_model.sv
/*
 * Operator model: watches the lamps and probes the line drivers, timing
 * each lamp phase and each pin-2 driver pulse in clocks.
 * Assumes it shares the sequencer clock and reset.
 */
`timescale 1ns/10ps
module pss_operator_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] lamps,
    input wire pss_pkg::pss_drivers_t drivers,
    output logic [15:0] tcLen_r,
    output logic [15:0] restLen_r,
    output logic [15:0] pulseLen_r,
    output logic [15:0] pulsePeriod_r,
    output logic [7:0] pulseCount_r
);
    import pss_pkg::*;
    logic [7:0] lampPrev_r; // Last lamp pattern seen
    logic [15:0] lampCnt_r; // Clocks in current pattern
    logic txPrev_r; // Last probed pin-2 level
    logic [15:0] sinceRise_r; // Clocks since last rising edge

    // Eye on the lamps: length of each lit phase
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lampPrev_r <= 8'h00;
            lampCnt_r <= 16'h0000;
            tcLen_r <= 16'h0000;
            restLen_r <= 16'h0000;
        end else if (lamps != lampPrev_r) begin
            // Phase ended, keep its length
            if (lampPrev_r == LAMPS_TC_ONLY) tcLen_r <= lampCnt_r;
            if (lampPrev_r == LAMPS_REST_ONLY) restLen_r <= lampCnt_r;
            lampPrev_r <= lamps;
            lampCnt_r <= 16'h0001;
        end else begin
            lampCnt_r <= lampCnt_r + 16'h0001;
        end
    end

    // Scope probe on pin 2: width, spacing and count of pulses
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txPrev_r <= 1'b0;
            sinceRise_r <= 16'h0000;
            pulseLen_r <= 16'h0000;
            pulsePeriod_r <= 16'h0000;
            pulseCount_r <= 8'h00;
        end else begin
            txPrev_r <= drivers.v24TxData;
            if (drivers.v24TxData && !txPrev_r) begin
                // First period is meaningless, the bench skips it
                pulsePeriod_r <= sinceRise_r;
                pulseCount_r <= pulseCount_r + 8'h01;
                sinceRise_r <= 16'h0001;
            end else begin
                if (!drivers.v24TxData && txPrev_r) pulseLen_r <= sinceRise_r;
                sinceRise_r <= sinceRise_r + 16'h0001;
            end
        end
    end
endmodule : pss_operator_model

// ===== pss_testbench.sv
/*
 * Self-checking bench for the self-test sequencer with shortened phases.
 * Assumes the operator model and the design package are compiled first.
 */
`timescale 1ns/10ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module testbench;
    import pss_pkg::*;
    localparam logic [19:0] TC_T = 20'h0003C; // 60 ticks, short first phase
    localparam logic [19:0] REST_T = 20'h00028; // 40 ticks, short second phase
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] mediumSwitch = 4'h0;
    logic dtrSwitch = 1'b0;
    logic checkFault = 1'b0;
    logic [7:0] lamps_r;
    logic selfTestActive_r;
    pss_drivers_t drivers_r;
    logic [15:0] tcLen, restLen, pulseLen, pulsePeriod;
    logic [7:0] pulseCount;
    int err_total = 0;
    int cmp_count = 0;
    int n;

    // 125 MHz clock
    initial begin
        forever #4 clock = ~clock;
    end

    pss_self_test #(.PHASE_TC_TICKS(TC_T), .PHASE_REST_TICKS(REST_T)) dut_u (
        .clock(clock), .reset_n(reset_n), .mediumSwitch(mediumSwitch),
        .dtrSwitch(dtrSwitch), .checkFault(checkFault), .lamps_r(lamps_r),
        .selfTestActive_r(selfTestActive_r), .drivers_r(drivers_r));

    pss_operator_model oper_u (
        .clock(clock), .reset_n(reset_n), .lamps(lamps_r), .drivers(drivers_r),
        .tcLen_r(tcLen), .restLen_r(restLen), .pulseLen_r(pulseLen),
        .pulsePeriod_r(pulsePeriod), .pulseCount_r(pulseCount));

    // Range test; tolerances cover tick jitter of about one tick
    function automatic bit inr(input int v, input int lo, input int hi);
        return (v >= lo) && (v <= hi);
    endfunction : inr

    // Power cycle with the switch at a given position
    task automatic power_up(input logic [3:0] sw);
        @(posedge clock);
        reset_n <= 1'b0;
        mediumSwitch <= sw;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
    endtask : power_up

    // Switch moved to self-test after power-up: nothing starts
    task automatic test_no_strap();
        power_up(4'h3);
        mediumSwitch <= 4'hF;
        repeat (14000) @(posedge clock);
        `CHK(lamps_r, LAMPS_OFF)
        `CHK(selfTestActive_r, 1'b0)
        `CHK(drivers_r, DRIVERS_IDLE)
        `CHK(pulseCount, 8'h00)
        $display("test_no_strap done");
    endtask : test_no_strap

    // Two full cycles: lamp pattern, phase lengths, pulses
    task automatic test_cycle();
        power_up(4'hF);
        repeat (2) @(posedge clock);
        `CHK(selfTestActive_r, 1'b1)
        n = 0;
        while (pulseCount < 8'h03 && n < 30000) begin
            @(posedge clock);
            n++;
            // Only the two phase patterns may ever show
            if (lamps_r !== LAMPS_TC_ONLY && lamps_r !== LAMPS_REST_ONLY)
                `CHK(lamps_r, LAMPS_TC_ONLY)
            if (drivers_r !== DRIVERS_PULSE)
                `CHK(drivers_r, DRIVERS_IDLE)
        end
        `CHK(pulseCount, 8'h03)
        `CHK(inr(tcLen, 7500, 8100), 1'b1)
        `CHK(inr(restLen, 4900, 5500), 1'b1)
        `CHK(inr(pulsePeriod, 12700, 13350), 1'b1)
        repeat (1500) @(posedge clock);
        `CHK(inr(pulseLen, 1150, 1450), 1'b1)
        `CHK(drivers_r, DRIVERS_IDLE)
        $display("test_cycle done");
    endtask : test_cycle

    // Held DTR switch keeps pin 20 low through a pulse
    task automatic test_dtr();
        power_up(4'hF);
        dtrSwitch <= 1'b1;
        n = 0;
        while (drivers_r.v24TxData !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        `CHK(drivers_r, DRIVERS_PULSE & 9'h1BF)
        repeat (1000) @(posedge clock);
        `CHK(drivers_r.v24TermReady, 1'b0)
        dtrSwitch <= 1'b0;
        $display("test_dtr done");
    endtask : test_dtr

    // Internal fault freezes lamps and stops pulses until power-up
    task automatic test_fault();
        power_up(4'hF);
        repeat (2000) @(posedge clock);
        checkFault <= 1'b1;
        @(posedge clock);
        checkFault <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(lamps_r, LAMPS_FAILED)
        repeat (14000) @(posedge clock);
        `CHK(lamps_r, LAMPS_FAILED)
        `CHK(drivers_r, DRIVERS_IDLE)
        `CHK(pulseCount, 8'h01)
        $display("test_fault done");
    endtask : test_fault

    // Verdict and end of run
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        test_no_strap();
        test_cycle();
        test_dtr();
        test_fault();
        test_done();
    end

    // Watchdog, well past the roughly 59000 clocks the tests need
    initial begin
        repeat (90000) @(posedge clock);
        err_total++;
        test_done();
    end
endmodule : testbench
